// >>> sbg_defs.vh
// Register map, field positions, reset values and counts for the baud generator
`ifndef SBG_DEFS_VH
`define SBG_DEFS_VH

`define SBG_OFS_RELOAD  4'h0
`define SBG_OFS_BUFFER  4'h4
`define SBG_OFS_STATE   4'h8
`define SBG_OFS_CTRL    4'hc

`define SBG_CTRL_MASTER 0
`define SBG_CTRL_I2C    1
`define SBG_CTRL_IDLE   2

`define SBG_ST_BUSY     0
`define SBG_ST_WCOL     1
`define SBG_ST_SCK      2

`define SBG_RST_RELOAD  8'h09
`define SBG_RST_CTRL    3'h0

`define SBG_TICK_DIV    2
`define SBG_EDGES_SPI   5'h10
`define SBG_EDGES_I2C   5'h12

`define SBG_RESP_OKAY   2'h0
`define SBG_RESP_SLVERR 2'h2

`endif

// >>> sbg_top.v
// Baud rate generator of a synchronous serial port, with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "sbg_defs.vh"

// Behaviour
// R1: The generator is the serial clock source whenever the port is master, in two-wire or SPI mode.
// R2: The reload value comes from the software-written reload register and is copied into the counter on every reload.
// R3: A software write to the shift buffer starts the counter when the port is master and the counter is not already busy.
// R4: When the transfer ends the counter stops by itself and the clock pin keeps its last level.
// R5: Reload fires twice per serial clock period, so one period is two counter rollovers.
// R6: Reload timing depends on mode: two-wire waits for the released clock line to read high, SPI does not.
// R7: The serial clock frequency is the oscillator frequency over four times the reload value plus one.
// R8: Software must not use reload values 0x00, 0x01 or 0x02 in two-wire master operation.
// R9: After each reload the counter runs down to zero and zero is the timeout that advances the clock.
// R10: The counter is paced by a divided enable derived from the oscillator, locked to instruction timing.
module sbg_top #(
  parameter DATA_W = 8
) (
  // Clock and reset
  input  wire              CLK_SYS,
  input  wire              RSTN,
  // AXI4-Lite write address
  input  wire [3:0]        S_AXI_AWADDR,
  input  wire              S_AXI_AWVALID,
  output wire              S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire [31:0]       S_AXI_WDATA,
  input  wire [3:0]        S_AXI_WSTRB,
  input  wire              S_AXI_WVALID,
  output wire              S_AXI_WREADY,
  // AXI4-Lite write response
  output reg  [1:0]        S_AXI_BRESP,
  output reg               S_AXI_BVALID,
  input  wire              S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire [3:0]        S_AXI_ARADDR,
  input  wire              S_AXI_ARVALID,
  output wire              S_AXI_ARREADY,
  // AXI4-Lite read data
  output reg  [31:0]       S_AXI_RDATA,
  output reg  [1:0]        S_AXI_RRESP,
  output reg               S_AXI_RVALID,
  input  wire              S_AXI_RREADY,
  // Serial clock pin
  input  wire              SCK_IN,
  output reg               SCK_OUT,
  output reg               SCK_OE
);

  // Bus and register state
  reg              aw_held;
  reg [3:0]        aw_addr;
  reg              w_held;
  reg [31:0]       w_data;
  reg              w_lane0;
  reg [DATA_W-1:0] reload;
  reg [DATA_W-1:0] shift_buf;
  reg [2:0]        ctrl;
  reg              wcol;
  // Generator state
  reg              tick_div;
  reg [DATA_W-1:0] counter;
  reg              busy;
  reg              sck;
  reg [4:0]        edges;
  reg              in_sync0;
  reg              in_sync1;

  wire tick = (tick_div == 1'b1);
  wire wr_go = aw_held && w_held && !S_AXI_BVALID;
  wire buf_wr = wr_go && (aw_addr == `SBG_OFS_BUFFER) && w_lane0;
  wire i2c = ctrl[`SBG_CTRL_I2C];
  wire master = ctrl[`SBG_CTRL_MASTER];
  wire [4:0] edge_total = i2c ? `SBG_EDGES_I2C : `SBG_EDGES_SPI;
  // Two-wire mode holds the count while the released line is pulled low
  wire stretch = i2c && sck && !in_sync1; // R6
  wire timeout = busy && tick && (counter == {DATA_W{1'b0}}) && !stretch; // R9
  wire start = buf_wr && master && !busy; // R3

  // Address decode shared by both bus directions
  function mapped;
    input [3:0] a;
    begin
      mapped = (a == `SBG_OFS_RELOAD) || (a == `SBG_OFS_BUFFER) ||
               (a == `SBG_OFS_STATE) || (a == `SBG_OFS_CTRL);
    end
  endfunction

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY  = !w_held;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // Write channel capture and response
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      aw_held      <= 1'b0;
      aw_addr      <= 4'h0;
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_lane0      <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `SBG_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[3:2], 2'b00};
      end
      if (S_AXI_WVALID && !w_held) begin
        w_held  <= 1'b1;
        w_data  <= S_AXI_WDATA;
        w_lane0 <= S_AXI_WSTRB[0];
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= mapped(aw_addr) ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // Software registers; collision flag set wins over its clear
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      reload    <= `SBG_RST_RELOAD;
      shift_buf <= {DATA_W{1'b0}};
      ctrl      <= `SBG_RST_CTRL;
      wcol      <= 1'b0;
    end else begin
      if (wr_go && w_lane0) begin
        case (aw_addr)
          `SBG_OFS_RELOAD: begin
            reload <= w_data[DATA_W-1:0]; // R2
          end
          `SBG_OFS_CTRL: begin
            ctrl <= w_data[2:0];
          end
          default: begin
          end
        endcase
      end
      if (start) begin
        shift_buf <= w_data[DATA_W-1:0];
      end
      if (buf_wr && busy) begin
        wcol <= 1'b1;
      end else if (wr_go && w_lane0 && aw_addr == `SBG_OFS_STATE && w_data[`SBG_ST_WCOL]) begin
        wcol <= 1'b0;
      end
    end
  end

  // Read channel, one cycle after the address is taken
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= `SBG_RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= mapped({S_AXI_ARADDR[3:2], 2'b00}) ? `SBG_RESP_OKAY : `SBG_RESP_SLVERR;
      case ({S_AXI_ARADDR[3:2], 2'b00})
        `SBG_OFS_RELOAD: S_AXI_RDATA <= {{(32-DATA_W){1'b0}}, reload};
        `SBG_OFS_BUFFER: S_AXI_RDATA <= {{(32-DATA_W){1'b0}}, shift_buf};
        `SBG_OFS_STATE:  S_AXI_RDATA <= {{(24-DATA_W){1'b0}}, counter, 5'h0, sck, wcol, busy};
        `SBG_OFS_CTRL:   S_AXI_RDATA <= {29'h0, ctrl};
        default:         S_AXI_RDATA <= 32'h0;
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Count enable: half an instruction cycle, giving Fosc/(4*(reload+1))
  always @(posedge CLK_SYS) begin
    if (!RSTN || start) begin
      tick_div <= 1'b0;
    end else begin
      tick_div <= ~tick_div; // R10 R7
    end
  end

  // Clock line level synchroniser
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      in_sync0 <= 1'b1;
      in_sync1 <= 1'b1;
    end else begin
      in_sync0 <= SCK_IN;
      in_sync1 <= in_sync0;
    end
  end

  // Down-counter, reload and clock toggling
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      counter <= {DATA_W{1'b0}};
      busy    <= 1'b0;
      sck     <= 1'b0;
      edges   <= 5'h0;
    end else if (!master) begin
      busy <= 1'b0;
      sck  <= i2c ? 1'b1 : ctrl[`SBG_CTRL_IDLE];
    end else if (start) begin
      busy    <= 1'b1; // R3
      counter <= reload; // R2
      edges   <= 5'h0;
    end else if (timeout) begin
      sck   <= ~sck; // R5
      edges <= edges + 5'h1;
      if (edges + 5'h1 == edge_total) begin
        busy <= 1'b0; // R4
      end else begin
        counter <= reload; // R2 R5
      end
    end else if (busy && tick && !stretch) begin
      counter <= counter - {{(DATA_W-1){1'b0}}, 1'b1}; // R9
    end else if (!busy) begin
      // Idle master: two-wire line released, SPI at its idle level
      sck <= i2c ? 1'b1 : ctrl[`SBG_CTRL_IDLE];
    end
  end

  // Pin drive: open-drain low in two-wire mode, push-pull in SPI mode
  always @(posedge CLK_SYS) begin
    if (!RSTN) begin
      SCK_OUT <= 1'b0;
      SCK_OE  <= 1'b0;
    end else if (!master) begin
      SCK_OUT <= 1'b0;
      SCK_OE  <= 1'b0;
    end else begin
      SCK_OUT <= i2c ? 1'b0 : sck; // R1
      SCK_OE  <= i2c ? (busy & ~sck) : 1'b1; // R1 R6
    end
  end

endmodule
`default_nettype wire

// >>> sbg_monitor.sv
// Port checks for the baud generator
`timescale 1ns/100ps
`default_nettype none
module sbg_monitor (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  // Read channels
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // Clock pin
  input wire logic        SCK_IN,
  input wire logic        SCK_OUT,
  input wire logic        SCK_OE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  property p_rst; $rose(RSTN) |-> !SCK_OE && S_AXI_ARREADY; endproperty
  a_rst: assert property (p_rst)
    else $error("reset state");
  property p_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_ans: assert property (p_ans)
    else $error("read late");
  property p_hld; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_hld: assert property (p_hld)
    else $error("read dropped");
  property p_blk; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_blk: assert property (p_blk)
    else $error("read overlap");
  property p_hi; S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi)
    else $error("upper bits");
  property p_half; $changed(SCK_OUT) && SCK_OE |=> $stable(SCK_OUT); endproperty
  a_half: assert property (p_half)
    else $error("short half");
  property p_rel; $fell(SCK_OE) |=> !SCK_OE; endproperty
  a_rel: assert property (p_rel)
    else $error("short release");
  property p_str; !SCK_OE && !SCK_IN |=> !SCK_OE; endproperty
  a_str: assert property (p_str)
    else $error("no stretch");
endmodule
bind sbg_top sbg_monitor u_mon (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .SCK_IN(SCK_IN), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE));
`default_nettype wire

// >>> sbg_slave_model.sv
// Clock line model: pull-up plus a slave that may hold it low
`timescale 1ns/100ps
`default_nettype none
module sbg_slave_model (
  input  wire logic sck_out,
  input  wire logic sck_oe,
  input  wire logic hold,
  output wire logic sck_w
);
  // Driver wins, else pull-up unless stretched
  assign sck_w = sck_oe ? sck_out : ~hold;
endmodule
`default_nettype wire

// >>> testbench.sv
// Bench for the baud generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 0, rstn = 0, awv = 0, wv = 0, arv = 0, hold = 0;
  logic [3:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  wire         awr, wrd, bv, arr, rv, so, oe, sw;
  wire  [31:0] rdt;
  wire  [1:0]  brs, rrs;
  int          err_count = 0, checks = 0;
  always #5 clk = ~clk;
  sbg_top DUT (.CLK_SYS(clk), .RSTN(rstn), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(brs), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdt),
    .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .SCK_IN(sw),
    .SCK_OUT(so), .SCK_OE(oe));
  sbg_slave_model SLV (.sck_out(so), .sck_oe(oe), .hold(hold), .sck_w(sw));
  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin err_count++; $display("Error %s exp %h got %h", n, e, g); end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    logic ak, wk, bk;
    logic [1:0] br;
    awa <= a; wd <= {24'h000000, d}; awv <= 1; wv <= 1; bk = 0; br = 2'h3;
    while (!bk) begin
      @(negedge clk); ak = awr; wk = wrd; bk = bv; br = brs;
      @(posedge clk); if (ak) awv <= 0; if (wk) wv <= 0;
    end
    chk("bresp", 32'h0, {30'h0, br});
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    logic ak, k;
    logic [1:0] rr;
    ara <= a; arv <= 1; k = 0; rr = 2'h3;
    while (!k) begin
      @(negedge clk); ak = arr; k = rv; d = rdt; rr = rrs;
      @(posedge clk); if (ak) arv <= 0;
    end
    chk("rresp", 32'h0, {30'h0, rr});
  endtask
  // Cycles until the wire level changes, 60 means none
  task automatic gap(output int c);
    logic v;
    v = sw; c = 0;
    while (sw === v && c < 60) begin @(negedge clk); c++; end
  endtask
  task automatic t_reg;
    logic [31:0] d;
    rreg(4'h0, d); chk("reload", 32'h09, d);
    rreg(4'hc, d); chk("ctrl", 32'h00, d);
    rreg(4'h8, d); chk("state", 32'h00, d);
  endtask
  task automatic t_spi;
    int c, i;
    logic [31:0] d;
    wreg(4'h0, 8'h02); wreg(4'hc, 8'h01); wreg(4'h4, 8'ha5);
    gap(c);
    for (i = 1; i < 16; i++) begin gap(c); chk("half", 2 * (2 + 1), c); end
    gap(c); chk("stop", 60, c);
    chk("level", 0, sw);
    rreg(4'h8, d); chk("busy", 0, d[0]);
    rreg(4'h4, d); chk("buffer", 32'ha5, d);
  endtask
  task automatic t_wcol;
    logic [31:0] d;
    wreg(4'h0, 8'h20); wreg(4'h4, 8'h11); wreg(4'h4, 8'h22);
    rreg(4'h8, d); chk("wcol", 3, d[1:0]);
    rreg(4'h4, d); chk("kept", 32'h11, d);
    wreg(4'h8, 8'h02);
    rreg(4'h8, d); chk("clear", 1, d[1:0]);
    wreg(4'hc, 8'h00);
    rreg(4'h8, d); chk("abort", 0, {oe, d[0]});
  endtask
  task automatic t_i2c;
    int c, n;
    wreg(4'h0, 8'h03); wreg(4'hc, 8'h03); wreg(4'h4, 8'h3c);
    n = 0; c = 0;
    while (c < 60) begin
      gap(c);
      if (c < 60) n++;
      if (n == 5) chk("high", 1, c >= 2 * (3 + 1));
      if (n == 3) begin
        @(posedge clk) hold <= 1;
        repeat (30) @(posedge clk);
        chk("stall", 0, oe);
        hold <= 0;
      end
    end
    chk("toggles", 18, n);
    chk("idle", 1, sw);
  endtask
  task tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    t_reg; t_spi; t_wcol; t_i2c;
    tally_and_finish;
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
